// file: rtl/pvmrb_bank.sv
// Contract
// - Early receive-valid bit enables RXDV before SFD in 10BASE-T.
// - Loopback-disable bit stops internal loopback in 10BASE-T half duplex.
// - CRC counter source bit: zero received data, one transmitted data.
// - Read-only low-rate bit reports MAC clock 125 or 25 MHz.
// - Station address sets management address and scrambler seed, default from straps.
// - Operating mode field defaults from upper straps at reset.
// - FIFO depth code maps to four through seven bytes, resets zero.
// - Indicator mode select codes 1..3, code zero reserved, default 11b.
// - Clock disable bit holds MAC clock pin low, default from strap.
// - Bit 2 forces channels 0/1 MDI or MDI-X when auto crossover off.
// - Bit 1 forces channels 2/3 MDI or MDI-X when auto crossover off.
// - Auto crossover disable bit zero enables automatic crossover.
// - Conditional parallel detect restricts success to advertised half duplex speeds.
// - Writing read bit latches selected advanced register; bit self-clears.
// - Seven-bit advanced address selects register 0..12, resets zero.
// - Read data port is read-only, holds latest latch, resets zero.
// - Polarity bit reports 10BASE-T receive polarity reversed.
`include "pvmrb_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pvmrb_bank #(
  parameter int ADV_AW = 7
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  soft_rst,
  input  wire logic [3:0]            config_straps,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [4:0]            reg_idx,
  input  wire pvmrb_pkg::pvmrb_word_t reg_wdata,
  output var  pvmrb_pkg::pvmrb_word_t reg_rdata,
  input  wire logic                  mac_clock_low_rate_select,
  input  wire logic                  ten_base_polarity_reversed,
  input  wire logic                  adv_lp_10_half,
  input  wire logic                  adv_lp_100_half,
  input  wire logic                  adv_local_10_half,
  input  wire logic                  adv_local_100_half,
  input  wire logic                  crossover_auto_choice,
  output logic [ADV_AW-1:0]          adv_addr,
  input  wire pvmrb_pkg::pvmrb_word_t adv_rdata,
  output logic [4:0]                 station_address_field,
  output logic                       early_rxdv_en,
  output logic                       ten_half_loopback_dis,
  output logic                       crc_count_tx_source,
  output logic [4:0]                 operating_mode_field,
  output logic [2:0]                 tx_fifo_depth_bytes,
  output pvmrb_pkg::pvmrb_ind_t      indicator_mode_select,
  output logic                       mac_clock_output_pin,
  output logic                       pairs01_crossed,
  output logic                       pairs23_crossed,
  output logic                       parallel_detect_ok_10,
  output logic                       parallel_detect_ok_100
);
  import pvmrb_pkg::*;
  // The indirect window is fixed at seven address bits
  if (ADV_AW != 7) begin : g_bad_aw
    $error("ADV_AW must be 7");
  end
  // ----------------------------------------
  // Strap capture and status synchronisers
  // ----------------------------------------
  logic [3:0] straps_s;
  logic [1:0] stat_s;
  pvmrb_sync #(.WIDTH(4)) u_strap_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (config_straps),
    .sync_out (straps_s)
  );
  pvmrb_sync #(.WIDTH(2)) u_stat_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({ten_base_polarity_reversed, mac_clock_low_rate_select}),
    .sync_out (stat_s)
  );
  // Straps loaded on the third clock after reset release, once synchronised
  logic [1:0] load_cnt_q;
  logic       load_now;
  assign load_now = (load_cnt_q == 2'h2);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      load_cnt_q <= 2'h0;
    end else if (load_cnt_q != 2'h3) begin
      load_cnt_q <= load_cnt_q + 2'h1;
    end
  end
  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_sm = reg_wr && (reg_idx == `PVMRB_IDX_SPECIAL);
  wire wr_em = reg_wr && (reg_idx == `PVMRB_IDX_EXTENDED);
  wire wr_mc = reg_wr && (reg_idx == `PVMRB_IDX_MODE_CTRL);
  wire wr_ap = reg_wr && (reg_idx == `PVMRB_IDX_ADDR_PORT);
  // ----------------------------------------
  // Fields kept across software reset
  // ----------------------------------------
  logic [4:0] phy_addr_q;
  logic       lpbk_dis_q;
  logic [4:0] mode_q;
  logic       clk_dis_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phy_addr_q <= 5'h00;
      lpbk_dis_q <= 1'b0;
      mode_q     <= 5'h00;
      clk_dis_q  <= 1'b0;
    end else if (load_now) begin
      phy_addr_q <= {3'h0, straps_s[1:0]};
      mode_q     <= {3'h0, straps_s[3:2]};
      clk_dis_q  <= straps_s[3];
    end else begin
      // Software reset deliberately absent here
      if (wr_sm) begin
        phy_addr_q <= reg_wdata[4:0];
        lpbk_dis_q <= reg_wdata[`PVMRB_SM_LPBK_DIS];
      end
      if (wr_em) begin
        mode_q    <= reg_wdata[15:11];
        clk_dis_q <= reg_wdata[`PVMRB_EM_CLK_DIS];
      end
    end
  end
  // ----------------------------------------
  // Fields returned to their reset values by either reset
  // ----------------------------------------
  logic       early_q;
  logic       crc_src_q;
  logic [1:0] fifo_q;
  logic [1:0] ind_q;
  logic       mdix01_q;
  logic       mdix23_q;
  logic       cond_pd_q;
  logic       xover_dis_q;
  always_ff @(posedge clock) begin
    if (sys_rst || soft_rst) begin
      early_q     <= 1'b0;
      crc_src_q   <= 1'b0;
      fifo_q      <= `PVMRB_RST_FIFO;
      ind_q       <= `PVMRB_RST_IND;
      mdix01_q    <= 1'b0;
      mdix23_q    <= 1'b0;
      cond_pd_q   <= 1'b0;
      xover_dis_q <= 1'b0;
    end else begin
      if (wr_sm) begin
        early_q   <= reg_wdata[`PVMRB_SM_EARLY_RXDV];
        crc_src_q <= reg_wdata[`PVMRB_SM_CRC_SRC];
      end
      if (wr_em) begin
        fifo_q    <= reg_wdata[10:9];
        ind_q     <= reg_wdata[5:4];
        mdix01_q  <= reg_wdata[`PVMRB_EM_MDIX01];
        mdix23_q  <= reg_wdata[`PVMRB_EM_MDIX23];
        cond_pd_q <= reg_wdata[`PVMRB_EM_COND_PD];
      end
      if (wr_mc) begin
        xover_dis_q <= reg_wdata[`PVMRB_MC_XOVER_DIS];
      end
    end
  end
  // ----------------------------------------
  // Indirect advanced register window
  // ----------------------------------------
  logic [6:0]  adv_addr_q;
  logic        rd_pend_q;
  logic [7:0]  ap_rsv_q;
  pvmrb_word_t adv_data_q;
  always_ff @(posedge clock) begin
    if (sys_rst || soft_rst) begin
      adv_addr_q <= `PVMRB_RST_ADDR;
      rd_pend_q  <= 1'b0;
      ap_rsv_q   <= 8'h00;
      adv_data_q <= `PVMRB_RST_DATA;
    end else begin
      // Read bit clears itself on the same clock as the latch
      rd_pend_q <= wr_ap && reg_wdata[`PVMRB_AP_READ];
      if (wr_ap) begin
        adv_addr_q <= reg_wdata[6:0];
        ap_rsv_q   <= reg_wdata[14:7];
      end
      if (rd_pend_q) begin
        // Out-of-range addresses latch zero
        adv_data_q <= (adv_addr_q <= `PVMRB_ADV_LAST) ? adv_rdata : 16'h0000;
      end
    end
  end
  assign adv_addr = adv_addr_q;
  // ----------------------------------------
  // Outputs steering the datapath
  // ----------------------------------------
  assign station_address_field = phy_addr_q;
  assign early_rxdv_en         = early_q;
  assign ten_half_loopback_dis = lpbk_dis_q;
  assign crc_count_tx_source   = crc_src_q;
  assign operating_mode_field  = mode_q;
  assign tx_fifo_depth_bytes   = {1'b0, fifo_q} + 3'h4;
  assign indicator_mode_select = pvmrb_ind_t'(ind_q);
  // Manual selection only while automatic crossover is off
  assign pairs01_crossed = xover_dis_q ? mdix01_q : crossover_auto_choice;
  assign pairs23_crossed = xover_dis_q ? mdix23_q : crossover_auto_choice;
  assign parallel_detect_ok_10  = adv_lp_10_half && (!cond_pd_q || adv_local_10_half);
  assign parallel_detect_ok_100 = adv_lp_100_half && (!cond_pd_q || adv_local_100_half);
  pvmrb_clkout u_clkout (
    .clock                (clock),
    .sys_rst              (sys_rst),
    .disable_i            (clk_dis_q),
    .low_rate             (stat_s[0]),
    .mac_clock_output_pin (mac_clock_output_pin)
  );
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  pvmrb_word_t rd_sm;
  pvmrb_word_t rd_em;
  pvmrb_word_t rd_ap;
  pvmrb_word_t rd_mc;
  pvmrb_word_t rd_li;
  assign rd_sm = {early_q, lpbk_dis_q, 6'h00, crc_src_q, stat_s[0], 1'b0, phy_addr_q};
  assign rd_em = {mode_q, fifo_q, 3'h0, ind_q, clk_dis_q, mdix01_q, mdix23_q, cond_pd_q};
  assign rd_ap = {rd_pend_q, ap_rsv_q, adv_addr_q};
  assign rd_mc = {10'h000, xover_dis_q, 5'h00};
  assign rd_li = {11'h000, stat_s[1], 4'h0};
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_idx)
        `PVMRB_IDX_MODE_CTRL: reg_rdata <= rd_mc;
        `PVMRB_IDX_SPECIAL:   reg_rdata <= rd_sm;
        `PVMRB_IDX_EXTENDED:  reg_rdata <= rd_em;
        `PVMRB_IDX_ADDR_PORT: reg_rdata <= rd_ap;
        `PVMRB_IDX_DATA_PORT: reg_rdata <= adv_data_q;
        `PVMRB_IDX_LINE_IND:  reg_rdata <= rd_li;
        default:              reg_rdata <= 16'h0000;
      endcase
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_read_latch;
    @(posedge clock) disable iff (sys_rst || soft_rst)
      (wr_ap && reg_wdata[15] && reg_wdata[6:0] <= 7'h0c && !soft_rst) ##1 (!wr_ap && !soft_rst)
      |=> (adv_data_q == $past(adv_rdata));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("advanced data not latched");
  property p_read_selfclear;
    @(posedge clock) disable iff (sys_rst || soft_rst)
      rd_pend_q && !(wr_ap && reg_wdata[15]) |=> !rd_pend_q;
  endproperty
  a_read_selfclear: assert property (p_read_selfclear) else $error("read bit stuck");
  property p_fifo_depth;
    @(posedge clock) disable iff (sys_rst)
      wr_em && !soft_rst |=> tx_fifo_depth_bytes[2] && (tx_fifo_depth_bytes[1:0] == $past(reg_wdata[10:9]));
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("fifo depth out of range");
  property p_manual_xover;
    @(posedge clock) disable iff (sys_rst)
      xover_dis_q |-> (pairs01_crossed == mdix01_q) && (pairs23_crossed == mdix23_q);
  endproperty
  a_manual_xover: assert property (p_manual_xover) else $error("manual crossover ignored");
  property p_auto_xover;
    @(posedge clock) disable iff (sys_rst)
      !xover_dis_q |-> (pairs01_crossed == crossover_auto_choice) && (pairs23_crossed == crossover_auto_choice);
  endproperty
  a_auto_xover: assert property (p_auto_xover) else $error("auto crossover ignored");
  property p_cond_pd;
    @(posedge clock) disable iff (sys_rst)
      cond_pd_q && !adv_local_100_half |-> !parallel_detect_ok_100;
  endproperty
  a_cond_pd: assert property (p_cond_pd) else $error("unadvertised parallel detect");
  property p_keep_addr;
    @(posedge clock) disable iff (sys_rst)
      soft_rst && !wr_sm && !load_now |=> phy_addr_q == $past(phy_addr_q);
  endproperty
  a_keep_addr: assert property (p_keep_addr) else $error("address lost on soft reset");
  property p_clk_low;
    @(posedge clock) disable iff (sys_rst)
      clk_dis_q [*2] |-> !mac_clock_output_pin;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("mac clock toggles while disabled");
  property p_ind_reset;
    @(posedge clock) $past(sys_rst) |-> ind_q == 2'b11 && fifo_q == 2'b00;
  endproperty
  a_ind_reset: assert property (p_ind_reset) else $error("bad reset defaults");
  property p_ind_write;
    @(posedge clock) disable iff (sys_rst)
      wr_em && !soft_rst |=> indicator_mode_select == $past(reg_wdata[5:4]);
  endproperty
  a_ind_write: assert property (p_ind_write) else $error("indicator mode not written");
  property p_addr_write;
    @(posedge clock) disable iff (sys_rst)
      wr_ap && !soft_rst |=> adv_addr == $past(reg_wdata[6:0]);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("advanced address not written");
  // Only a read request or a reset may move the data port
  property p_data_hold;
    @(posedge clock) disable iff (sys_rst || soft_rst)
      !rd_pend_q && !soft_rst |=> $stable(adv_data_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data port changed without a read");
endmodule : pvmrb_bank
`default_nettype wire

// file: rtl/pvmrb_clkout.sv
`timescale 1ns/10ps
`default_nettype none
module pvmrb_clkout (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic disable_i,
  input  wire logic low_rate,
  output var  logic mac_clock_output_pin
);
  // ----------------------------------------
  // Divided clock; a stand-in for the real PLL output
  // ----------------------------------------
  logic [2:0] cnt_q;
  logic       lim;
  assign lim = low_rate ? (cnt_q == 3'h3) : (cnt_q == 3'h0);
  always_ff @(posedge clock) begin
    if (sys_rst || disable_i) begin
      cnt_q                <= 3'h0;
      mac_clock_output_pin <= 1'b0;
    end else begin
      cnt_q                <= lim ? 3'h0 : cnt_q + 3'h1;
      mac_clock_output_pin <= lim ? ~mac_clock_output_pin : mac_clock_output_pin;
    end
  end
endmodule : pvmrb_clkout
`default_nettype wire

// file: rtl/pvmrb_pkg.sv
package pvmrb_pkg;
  typedef enum logic [1:0] {
    PVMRB_IND_RSV   = 2'b00,
    PVMRB_IND_MODE1 = 2'b01,
    PVMRB_IND_MODE2 = 2'b10,
    PVMRB_IND_MODE3 = 2'b11
  } pvmrb_ind_t;
  typedef logic [15:0] pvmrb_word_t;
endpackage : pvmrb_pkg

// file: rtl/pvmrb_regs.svh
`ifndef PVMRB_REGS_SVH
`define PVMRB_REGS_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define PVMRB_IDX_MODE_CTRL   5'h11
`define PVMRB_IDX_SPECIAL     5'h12
`define PVMRB_IDX_EXTENDED    5'h13
`define PVMRB_IDX_ADDR_PORT   5'h14
`define PVMRB_IDX_DATA_PORT   5'h15
`define PVMRB_IDX_LINE_IND    5'h1b
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PVMRB_SM_EARLY_RXDV   15
`define PVMRB_SM_LPBK_DIS     14
`define PVMRB_SM_CRC_SRC      7
`define PVMRB_SM_LOW_RATE     6
`define PVMRB_EM_FIFO_LSB     9
`define PVMRB_EM_IND_LSB      4
`define PVMRB_EM_CLK_DIS      3
`define PVMRB_EM_MDIX01       2
`define PVMRB_EM_MDIX23       1
`define PVMRB_EM_COND_PD      0
`define PVMRB_MC_XOVER_DIS    5
`define PVMRB_AP_READ         15
`define PVMRB_LI_POL          4
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PVMRB_RST_FIFO        2'h0
`define PVMRB_RST_IND         2'h3
`define PVMRB_RST_ADDR        7'h00
`define PVMRB_RST_DATA        16'h0000
`define PVMRB_ADV_LAST        7'h0c
`define PVMRB_AP_RSV_VALUE    8'h03
`endif

// file: rtl/pvmrb_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pvmrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be positive");
  end
  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pvmrb_sync
`default_nettype wire

// file: testbench/pvmrb_adv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Advanced register set behind the indirect port
// ----------------------------------------
module pvmrb_adv_model (
  input  wire logic        clock,
  input  wire logic [6:0]  adv_addr,
  output var  logic [15:0] adv_rdata
);
  logic [15:0] junk_q = 16'h3c3c;
  // Nothing answers above 12; a moving pattern keeps a stale word from passing for data
  always_ff @(posedge clock) begin
    junk_q <= ~junk_q ^ 16'h0001;
  end
  assign adv_rdata = (adv_addr <= 7'h0c) ? (16'h5a00 | {9'h000, adv_addr}) : junk_q;
endmodule : pvmrb_adv_model
`default_nettype wire

// file: testbench/tb_phy_vendor_mode_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
module tb_phy_vendor_mode_register_bank;
  import pvmrb_pkg::*;
  typedef struct {logic [4:0] idx; logic [15:0] wd; logic [15:0] exp;} pvmrb_row_t;
  logic        clock, sys_rst, soft_rst, reg_wr, reg_rd, low_rate, pol;
  logic        lp10, lp100, lc10, lc100, xauto, erx, lpd, crc, mclk, p01, p23, pd10, pd100, xd;
  logic [3:0]  config_straps;
  logic [4:0]  reg_idx, station, opmode;
  logic [6:0]  adv_addr;
  logic [2:0]  depth;
  logic [15:0] sm, em;
  pvmrb_word_t reg_wdata, reg_rdata, adv_rdata;
  pvmrb_ind_t  ind;
  int          n_mismatch, tests_run;
  pvmrb_row_t  rows [11] = '{'{5'h12, 16'hffff, 16'hc09f}, '{5'h12, 16'h0040, 16'h0000},
    '{5'h12, 16'h8085, 16'h8085}, '{5'h13, 16'hffff, 16'hfe3f}, '{5'h13, 16'h0210, 16'h0210},
    '{5'h13, 16'h0420, 16'h0420}, '{5'h13, 16'h4e36, 16'h4e36}, '{5'h11, 16'hffff, 16'h0020},
    '{5'h1b, 16'hffff, 16'h0000}, '{5'h15, 16'hffff, 16'h0000}, '{5'h05, 16'hffff, 16'h0000}};
  logic [6:0]  al [4] = '{7'h00, 7'h0c, 7'h0d, 7'h05};

  pvmrb_bank i_pvmrb_bank (.clock(clock), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .config_straps(config_straps), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mac_clock_low_rate_select(low_rate),
    .ten_base_polarity_reversed(pol), .adv_lp_10_half(lp10), .adv_lp_100_half(lp100),
    .adv_local_10_half(lc10), .adv_local_100_half(lc100), .crossover_auto_choice(xauto),
    .adv_addr(adv_addr), .adv_rdata(adv_rdata), .station_address_field(station),
    .early_rxdv_en(erx), .ten_half_loopback_dis(lpd), .crc_count_tx_source(crc),
    .operating_mode_field(opmode), .tx_fifo_depth_bytes(depth), .indicator_mode_select(ind),
    .mac_clock_output_pin(mclk), .pairs01_crossed(p01), .pairs23_crossed(p23),
    .parallel_detect_ok_10(pd10), .parallel_detect_ok_100(pd100));
  pvmrb_adv_model i_pvmrb_adv_model (.clock(clock), .adv_addr(adv_addr), .adv_rdata(adv_rdata));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_idx   <= i;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // Sample two edges on so either reading of the one-cycle answer is covered
  task automatic rd(input logic [4:0] i, input logic [15:0] exp);
    @(posedge clock);
    reg_rd  <= 1'b1;
    reg_idx <= i;
    @(posedge clock);
    reg_rd  <= 1'b0;
    @(posedge clock);
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic chk_outs();
    chk({erx, lpd, crc, station, opmode, depth}, {sm[15], sm[14], sm[7], sm[4:0], em[15:11], {1'b0, em[10:9]} + 3'h4});
    chk({12'h000, ind, p01, p23}, {12'h000, em[5:4], xd ? em[2] : xauto, xd ? em[1] : xauto});
  endtask : chk_outs

  task automatic clk_chk(input logic run);
    int   n;
    logic last;
    n    = 0;
    // Let a just-written disable bit reach the pin before watching it
    @(posedge clock);
    #1;
    last = mclk;
    repeat (16) begin
      @(posedge clock);
      #1;
      if (mclk !== last) n++;
      last = mclk;
    end
    chk(16'(n != 0), 16'(run));
    if (!run) chk(16'(mclk), 16'h0000);
  endtask : clk_chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    {sys_rst, soft_rst, reg_wr, reg_rd, low_rate, pol} = 6'b100000;
    {lp10, lp100, lc10, lc100, xauto} = 5'b00000;
    config_straps = 4'h6;
    reg_idx       = 5'h00;
    reg_wdata     = 16'h0000;
    n_mismatch    = 0;
    tests_run     = 0;
    // Straps 0110: address 2, mode 1, clock output enabled
    sm = 16'h0002;
    em = 16'h0830;
    xd = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    rd(5'h12, sm);
    rd(5'h13, em);
    rd(5'h15, 16'h0000);
    chk_outs();
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].wd);
      if (rows[k].idx == 5'h12) sm = rows[k].exp;
      if (rows[k].idx == 5'h13) em = rows[k].exp;
      if (rows[k].idx == 5'h11) xd = rows[k].exp[5];
      rd(rows[k].idx, rows[k].exp);
      chk_outs();
    end
    for (int i = 0; i < 16; i++) begin
      xd = i[3];
      wr(5'h11, {10'h000, xd, 5'h00});
      em = (em & 16'hfff8) | {13'h0000, i[1], i[2], i[0]};
      wr(5'h13, em);
      lp10  <= i[1];
      lp100 <= i[1];
      lc10  <= i[2];
      lc100 <= !i[2];
      xauto <= i[2];
      @(posedge clock);
      #1;
      chk_outs();
      chk({14'h0000, pd10, pd100}, {14'h0000, i[1] & (!i[0] | i[2]), i[1] & (!i[0] | !i[2])});
    end
    foreach (al[k]) begin
      wr(5'h14, {1'b1, 8'h03, al[k]});
      @(posedge clock);
      rd(5'h14, {1'b0, 8'h03, al[k]});
      chk(16'(adv_addr), 16'(al[k]));
      rd(5'h15, (al[k] <= 7'h0c) ? (16'h5a00 | {9'h000, al[k]}) : 16'h0000);
    end
    // Address moved without the read bit: data port must hold the last latch
    wr(5'h14, {1'b0, 8'h03, 7'h03});
    rd(5'h15, 16'h5a05);
    @(posedge clock);
    low_rate <= 1'b1;
    pol      <= 1'b1;
    repeat (4) @(posedge clock);
    rd(5'h12, sm | 16'h0040);
    rd(5'h1b, 16'h0010);
    clk_chk(1'b1);
    em = em | 16'h0008;
    wr(5'h13, em);
    clk_chk(1'b0);
    @(posedge clock);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    repeat (2) @(posedge clock);
    sm = sm & 16'h401f;
    em = (em & 16'hf808) | 16'h0030;
    // Crossover disable is not kept across software reset
    xd = 1'b0;
    rd(5'h12, sm | 16'h0040);
    rd(5'h13, em);
    rd(5'h15, 16'h0000);
    rd(5'h11, 16'h0000);
    chk_outs();
    clk_chk(1'b0);
    // Hardware reset in mid-run reloads the straps, this time with the clock held off
    @(posedge clock);
    sys_rst       <= 1'b1;
    config_straps <= 4'hb;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(reg_rdata, 16'h0000);
    sm = 16'h0003;
    em = 16'h1038;
    rd(5'h12, sm | 16'h0040);
    rd(5'h13, em);
    rd(5'h15, 16'h0000);
    chk_outs();
    clk_chk(1'b0);
    conclude();
  end
endmodule : tb_phy_vendor_mode_register_bank
`default_nettype wire
